/* File: design/scg_pkg.sv */
// Constants, types and helpers of the system clock generation unit
// Overview of operation
// R1: In host mode the primary reference pin is the clock reference, in agent mode the bus clock input is.
// R2: The bus sync output carries the reference or its half, as the halving strap caught at reset picks.
// R3: Each bus clock output carries the reference or its half, picked by its own bit in the output clock control register.
// R4: The system bus clock ratio is the system PLL factor times one plus the halving strap.
// R5: Both PLL factors come from the low reset configuration word, caught from pins at reset or from a fixed option.
// R6: The memory controller clock is the system bus clock times one plus its mode bit, and the memory bus clock pair is half of it.
// R7: The local unit clock is the system bus clock times one plus its mode bit, then divided for the local outputs.
// R8: The local bus clocks are one half, one quarter or one eighth of the local unit clock, by the divider select field.
// R9: Configurable unit clocks start at a default ratio, can be changed by a register, and can be switched off.
// R10: Ethernet, two-wire, security and both USB unit clocks take off, full, half or third rate and start at third.
// R11: The two bus controllers and the DMA complex run at full rate by default and can only be switched off.
// R12: Software keeps the security and USB ratios low enough for their speed grade limit.
// R13: The system PLL factor code 0000 means 16, codes 0010 to 1111 mean 2 to 15, and 0001 is reserved.
// R14: The configuring party keeps the system bus and core clock rates inside their allowed ranges.
// R15: A unit clock ratio change or switch-off takes effect without runt pulses.
package scg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int NUM_BUS_OUT = 5;
  localparam int NUM_LCLK = 3;
  localparam int NUM_RATIO_UNITS = 6;
  localparam int NUM_UNITS = 9;

  localparam logic [ADDR_W-1:0] SYSTEM_CLOCK_CONTROL_REG_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] OUTPUT_CLOCK_CONTROL_REG_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] LOCAL_BUS_CLOCK_REG_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] RESET_CONFIG_WORD_LOW_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] STAT_OFF = 8'h10;

  // Unit ratio fields are two bits each from bit 0; on/off bits follow
  localparam int SYSTEM_CLOCK_CONTROL_REG_ONOFF_LSB = 12;
  localparam logic [DATA_W-1:0] SYSTEM_CLOCK_CONTROL_REG_RST = 32'h0000_7FFF;
  localparam logic [DATA_W-1:0] SYSTEM_CLOCK_CONTROL_REG_MASK = 32'h0000_7FFF;
  localparam int OUTPUT_CLOCK_CONTROL_REG_HALVE_LSB = 0;
  localparam logic [DATA_W-1:0] OUTPUT_CLOCK_CONTROL_REG_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] OUTPUT_CLOCK_CONTROL_REG_MASK = 32'h0000_001F;
  localparam int LDIV_LSB = 0;
  localparam int LDIV_W = 2;
  localparam logic [DATA_W-1:0] LOCAL_BUS_CLOCK_REG_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] LOCAL_BUS_CLOCK_REG_MASK = 32'h0000_0003;
  localparam logic [1:0] LDIV_2 = 2'h0;
  localparam logic [1:0] LDIV_4 = 2'h1;
  localparam logic [1:0] LDIV_8 = 2'h2;

  localparam int SYSTEM_PLL_FACTOR_LSB = 0;
  localparam int SYSTEM_PLL_FACTOR_W = 4;
  localparam int CORE_LSB = 4;
  localparam int CORE_W = 7;
  localparam int MEMCTL_CLOCK_MODE_BIT = 11;
  localparam int LOCAL_UNIT_CLOCK_MODE_BIT = 12;
  localparam logic [DATA_W-1:0] RCW_HARD_DEF = 32'h0000_0004;
  // Only the factor and mode fields are kept; the rest of the word reads 0
  localparam logic [DATA_W-1:0] CFGW_MASK = 32'h0000_1FFF;

  localparam int STAT_FACT_LSB = 0;
  localparam int STAT_RATIO_LSB = 8;
  localparam int STAT_HOST_BIT = 16;
  localparam int STAT_RSVD_BIT = 17;
  localparam int STAT_HALVE_BIT = 18;

  // The system bus clock runs at half of clk in this model
  localparam logic [1:0] CSB_DIV = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UR_OFF = 2'h0,
    UR_FULL = 2'h1,
    UR_HALF = 2'h2,
    UR_THIRD = 2'h3
  } scg_ratio_t;

  function automatic logic [4:0] system_pll_factor_decode(input logic [3:0] code);
    case (code)
      4'h0: system_pll_factor_decode = 5'h10;
      4'h1: system_pll_factor_decode = 5'h00;
      default: system_pll_factor_decode = {1'h0, code};
    endcase
  endfunction : system_pll_factor_decode

  function automatic logic [1:0] ratio_reload(input scg_ratio_t r);
    case (r)
      UR_HALF: ratio_reload = 2'h1;
      UR_THIRD: ratio_reload = 2'h2;
      default: ratio_reload = 2'h0;
    endcase
  endfunction : ratio_reload

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == SYSTEM_CLOCK_CONTROL_REG_OFF) || (a == OUTPUT_CLOCK_CONTROL_REG_OFF) || (a == LOCAL_BUS_CLOCK_REG_OFF) ||
               (a == RESET_CONFIG_WORD_LOW_OFF) || (a == STAT_OFF);
  endfunction : addr_hit

  function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nw, input logic [STRB_W-1:0] strb,
      input logic [DATA_W-1:0] mask);
    logic [DATA_W-1:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    apply_strb = (old & ~m) | (nw & m);
  endfunction : apply_strb
endpackage : scg_pkg

/* File: design/scg_div_if.sv */
// Carrier between the clock unit and one unit clock divider
`timescale 1ns/100ps
interface scg_div_if;
  import scg_pkg::*;
  logic tick;
  scg_ratio_t ratio;
  logic en;
  modport div (input tick, input ratio, output en);
  modport ctl (output tick, output ratio, input en);
endinterface : scg_div_if

/* File: design/scg_unit_div.sv */
// Unit clock divider producing one enable pulse per divided period
`timescale 1ns/100ps
module scg_unit_div (
  input wire logic clk,
  input wire logic rst_b,
  scg_div_if.div dv
);
  import scg_pkg::*;

  logic [1:0] cnt_q;
  logic en_q;

  // A new ratio is taken only when the running period has ended, so a change
  // never shortens the spacing of two pulses into a runt
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 2'h0;
      en_q <= 1'h0;
    end else if (dv.tick && cnt_q == 2'h0) begin
      cnt_q <= ratio_reload(dv.ratio); // see R15
      en_q <= (dv.ratio != UR_OFF); // see R9
    end else begin
      if (dv.tick) cnt_q <= cnt_q - 2'h1;
      en_q <= 1'h0;
    end
  end

  assign dv.en = en_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_off_quiet: assert property ( // see R11
    (dv.ratio == UR_OFF && cnt_q == 2'h0) |=> !en_q)
    else $error("unit enable pulsed while switched off");
  chk_third_gap: assert property ( // see R15
    (en_q && cnt_q == 2'h2) |=> !en_q [*3])
    else $error("third rate pulse spacing broken");
endmodule : scg_unit_div

/* File: design/scg_clock_unit.sv */
// System clock generation unit: reference select, dividers and unit clock ratios
`timescale 1ns/100ps
module scg_clock_unit #(
  parameter logic [scg_pkg::DATA_W-1:0] RCW_HARD = scg_pkg::RCW_HARD_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic host_mode_strap,
  input wire logic primary_ref_input,
  input wire logic bus_clock_input,
  input wire logic input_halving_strap,
  input wire logic rcw_hard_sel,
  input wire logic [scg_pkg::DATA_W-1:0] reset_config_word_low,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [scg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [scg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [scg_pkg::STRB_W-1:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [scg_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [scg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic bus_sync_output,
  output logic [scg_pkg::NUM_BUS_OUT-1:0] bus_clock_output_n,
  output logic memory_bus_clock_out,
  output logic memory_bus_clock_out_b,
  output logic local_sync_output,
  output logic [scg_pkg::NUM_LCLK-1:0] local_bus_clock_outputs,
  output logic [scg_pkg::NUM_UNITS-1:0] unit_clk_en
);
  import scg_pkg::*;

  logic cap_done_q;
  logic host_q;
  logic halve_q;
  logic [DATA_W-1:0] reset_config_word_low_q;
  logic [DATA_W-1:0] rcw_src;
  logic [DATA_W-1:0] system_clock_control_reg_q;
  logic [DATA_W-1:0] output_clock_control_reg_q;
  logic [DATA_W-1:0] local_bus_clock_reg_q;
  logic [4:0] sys_fact;
  logic [4:0] sys_fact_q;
  logic [5:0] csb_ratio_q;
  logic rsvd_q;

  // Straps and the configuration word are caught on the first edge after
  // reset release, never by the asynchronous reset itself
  assign rcw_src = rcw_hard_sel ? RCW_HARD : reset_config_word_low;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_done_q <= 1'h0;
      host_q <= 1'h0;
      halve_q <= 1'h0;
      reset_config_word_low_q <= 32'h0000_0000;
    end else if (!cap_done_q) begin
      cap_done_q <= 1'h1;
      host_q <= host_mode_strap;
      halve_q <= input_halving_strap;
      reset_config_word_low_q <= rcw_src & CFGW_MASK; // see R5
    end
  end

  assign sys_fact = system_pll_factor_decode(reset_config_word_low_q[SYSTEM_PLL_FACTOR_LSB +: SYSTEM_PLL_FACTOR_W]); // see R13

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_fact_q <= 5'h00;
      csb_ratio_q <= 6'h00;
      rsvd_q <= 1'h0;
    end else begin
      sys_fact_q <= sys_fact;
      csb_ratio_q <= halve_q ? {sys_fact, 1'h0} : {1'h0, sys_fact}; // see R4
      rsvd_q <= (sys_fact == 5'h00);
    end
  end

  // Reference selection and halving
  logic ref_sel;
  logic ref_s_q;
  logic ref_d_q;
  logic ref_half_q;
  logic sync_q;
  logic [NUM_BUS_OUT-1:0] bout_q;

  assign ref_sel = host_q ? primary_ref_input : bus_clock_input; // see R1

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_s_q <= 1'h0;
      ref_d_q <= 1'h0;
      ref_half_q <= 1'h0;
    end else begin
      ref_s_q <= ref_sel;
      ref_d_q <= ref_s_q;
      if (ref_s_q && !ref_d_q) ref_half_q <= !ref_half_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= 1'h0;
      bout_q <= '0;
    end else begin
      sync_q <= halve_q ? ref_half_q : ref_s_q; // see R2
      for (int i = 0; i < NUM_BUS_OUT; i++) begin
        bout_q[i] <= output_clock_control_reg_q[OUTPUT_CLOCK_CONTROL_REG_HALVE_LSB + i] ? ref_half_q : ref_s_q; // see R3
      end
    end
  end

  // System bus clock enable, with memory and local unit rates at 1x or 2x
  logic [1:0] csb_cnt_q;
  logic csb_tick_q;
  logic mem_mode;
  logic lbiu_mode;
  logic ddr_tick;
  logic lbiu_tick;
  logic mck_q;
  logic mckb_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csb_cnt_q <= 2'h0;
      csb_tick_q <= 1'h0;
    end else if (csb_cnt_q == CSB_DIV - 2'h1) begin
      csb_cnt_q <= 2'h0;
      csb_tick_q <= 1'h1;
    end else begin
      csb_cnt_q <= csb_cnt_q + 2'h1;
      csb_tick_q <= 1'h0;
    end
  end

  assign mem_mode = reset_config_word_low_q[MEMCTL_CLOCK_MODE_BIT];
  assign lbiu_mode = reset_config_word_low_q[LOCAL_UNIT_CLOCK_MODE_BIT];
  assign ddr_tick = cap_done_q && (mem_mode || csb_tick_q); // see R6
  assign lbiu_tick = cap_done_q && (lbiu_mode || csb_tick_q); // see R7

  // The pair toggles once per memory controller tick, giving half its rate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mck_q <= 1'h0;
      mckb_q <= 1'h1;
    end else if (ddr_tick) begin
      mck_q <= !mck_q; // see R6
      mckb_q <= mck_q;
    end
  end

  // Local bus divider
  logic [2:0] lcnt_q;
  logic lbit;
  logic lsync_q;
  logic [NUM_LCLK-1:0] lclk_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lcnt_q <= 3'h0;
    end else if (lbiu_tick) begin
      lcnt_q <= lcnt_q + 3'h1;
    end
  end

  always_comb begin
    case (local_bus_clock_reg_q[LDIV_LSB +: LDIV_W])
      LDIV_2: lbit = lcnt_q[0];
      LDIV_4: lbit = lcnt_q[1];
      default: lbit = lcnt_q[2];
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lsync_q <= 1'h0;
      lclk_q <= '0;
    end else begin
      lsync_q <= lbit; // see R8
      lclk_q <= {NUM_LCLK{lbit}};
    end
  end

  // Unit clock dividers
  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
    scg_div_if u_if ();
    assign u_if.tick = csb_tick_q;
    if (g < NUM_RATIO_UNITS) begin : g_ratio
      assign u_if.ratio = scg_ratio_t'(system_clock_control_reg_q[2*g +: 2]); // see R10
    end else begin : g_onoff
      assign u_if.ratio = system_clock_control_reg_q[SYSTEM_CLOCK_CONTROL_REG_ONOFF_LSB + g - NUM_RATIO_UNITS] ? UR_FULL : UR_OFF; // see R11
    end
    scg_unit_div u_div (
      .clk(clk),
      .rst_b(rst_b),
      .dv(u_if.div)
    );
    assign unit_clk_en[g] = u_if.en;
  end

  // Register bus: one write and one read outstanding at most
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic arready_q;
  logic rvalid_q;
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [STRB_W-1:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] stat_word;
  logic do_wr;

  assign do_wr = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awready_q <= 1'h0;
      wready_q <= 1'h0;
      aw_full_q <= 1'h0;
      w_full_q <= 1'h0;
      bvalid_q <= 1'h0;
      bresp_q <= RESP_OKAY;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        waddr_q <= s_axi_awaddr;
        aw_full_q <= 1'h1;
        awready_q <= 1'h0;
      end else begin
        awready_q <= !aw_full_q && !bvalid_q && !do_wr;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_full_q <= 1'h1;
        wready_q <= 1'h0;
      end else begin
        wready_q <= !w_full_q && !bvalid_q && !do_wr;
      end
      if (do_wr) begin
        aw_full_q <= 1'h0;
        w_full_q <= 1'h0;
        bvalid_q <= 1'h1;
        bresp_q <= addr_hit(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'h0;
      end
    end
  end

  // Read-only words ignore writes but still answer OKAY
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      system_clock_control_reg_q <= SYSTEM_CLOCK_CONTROL_REG_RST; // see R9
      output_clock_control_reg_q <= OUTPUT_CLOCK_CONTROL_REG_RST;
      local_bus_clock_reg_q <= LOCAL_BUS_CLOCK_REG_RST;
    end else if (do_wr) begin
      case (waddr_q)
        SYSTEM_CLOCK_CONTROL_REG_OFF: system_clock_control_reg_q <= apply_strb(system_clock_control_reg_q, wdata_q, wstrb_q, SYSTEM_CLOCK_CONTROL_REG_MASK); // see R9
        OUTPUT_CLOCK_CONTROL_REG_OFF: output_clock_control_reg_q <= apply_strb(output_clock_control_reg_q, wdata_q, wstrb_q, OUTPUT_CLOCK_CONTROL_REG_MASK);
        LOCAL_BUS_CLOCK_REG_OFF: local_bus_clock_reg_q <= apply_strb(local_bus_clock_reg_q, wdata_q, wstrb_q, LOCAL_BUS_CLOCK_REG_MASK);
        default: ;
      endcase
    end
  end

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[STAT_FACT_LSB +: 5] = sys_fact_q;
    stat_word[STAT_RATIO_LSB +: 6] = csb_ratio_q;
    stat_word[STAT_HOST_BIT] = host_q;
    stat_word[STAT_RSVD_BIT] = rsvd_q;
    stat_word[STAT_HALVE_BIT] = halve_q;
    case (s_axi_araddr)
      SYSTEM_CLOCK_CONTROL_REG_OFF: rd_word = system_clock_control_reg_q;
      OUTPUT_CLOCK_CONTROL_REG_OFF: rd_word = output_clock_control_reg_q;
      LOCAL_BUS_CLOCK_REG_OFF: rd_word = local_bus_clock_reg_q;
      RESET_CONFIG_WORD_LOW_OFF: rd_word = reset_config_word_low_q;
      STAT_OFF: rd_word = stat_word;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h1;
      rdata_q <= rd_word;
      rresp_q <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'h0;
      arready_q <= 1'h1;
    end else if (!rvalid_q) begin
      arready_q <= 1'h1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign bus_sync_output = sync_q;
  assign bus_clock_output_n = bout_q;
  assign memory_bus_clock_out = mck_q;
  assign memory_bus_clock_out_b = mckb_q;
  assign local_sync_output = lsync_q;
  assign local_bus_clock_outputs = lclk_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_ref_select: assert property ( // see R1
    cap_done_q |=> ref_s_q == (host_q ? $past(primary_ref_input) : $past(bus_clock_input)))
    else $error("reference taken from the wrong input");
  chk_sync_plain: assert property ( // see R2
    (cap_done_q && !halve_q) |-> ##2 sync_q == $past(ref_sel, 2))
    else $error("sync output does not follow reference");
  chk_sync_halved: assert property ( // see R2
    (cap_done_q && halve_q && ref_s_q && !ref_d_q) |=> ##1 sync_q != $past(sync_q))
    else $error("halved sync output missed a reference edge");
  chk_bus_out_plain: assert property ( // see R3
    (cap_done_q && !output_clock_control_reg_q[OUTPUT_CLOCK_CONTROL_REG_HALVE_LSB]) |=> bout_q[0] == $past(ref_s_q))
    else $error("bus clock output zero not undivided");
  chk_csb_sixteen: assert property ( // see R4
    (cap_done_q && reset_config_word_low_q[SYSTEM_PLL_FACTOR_LSB +: SYSTEM_PLL_FACTOR_W] == 4'h0 && halve_q) |=> csb_ratio_q == 6'h20)
    else $error("system bus ratio wrong for factor sixteen");
  chk_system_pll_factor_three: assert property ( // see R13
    (reset_config_word_low_q[SYSTEM_PLL_FACTOR_LSB +: SYSTEM_PLL_FACTOR_W] == 4'h3) |=> sys_fact_q == 5'h03)
    else $error("system factor decode wrong");
  chk_rcw_capture: assert property ( // see R5
    !cap_done_q |=> reset_config_word_low_q == ($past(rcw_src) & CFGW_MASK))
    else $error("configuration word not caught at reset release");
  chk_mck_double: assert property ( // see R6
    (cap_done_q && mem_mode) |=> mck_q != $past(mck_q))
    else $error("memory clock not at doubled rate");
  chk_mck_pair: assert property ( // see R6
    mck_q != mckb_q)
    else $error("memory clock pair not complementary");
  chk_lbiu_double: assert property ( // see R7
    (cap_done_q && lbiu_mode) |=> lcnt_q == $past(lcnt_q) + 3'h1)
    else $error("local unit clock not at doubled rate");
  chk_lclk_eighth: assert property ( // see R8
    (local_bus_clock_reg_q[LDIV_LSB +: LDIV_W] == LDIV_8 && lcnt_q == 3'h3 && lbiu_tick) |=> ##1 lsync_q)
    else $error("local clock eighth divide wrong");
  chk_ratio_default: assert property ( // see R10
    !$past(rst_b) |-> system_clock_control_reg_q == SYSTEM_CLOCK_CONTROL_REG_RST)
    else $error("unit ratios not at default after reset");
endmodule : scg_clock_unit

/* File: bench/scg_board_clk.sv */
// Board oscillators feeding the reference pins of the clock unit
`timescale 1ns/100ps
module scg_board_clk #(
  parameter int HALF_PRI = 4,
  parameter int HALF_BUS = 6
) (
  input wire logic clk,
  input wire logic host_mode,
  output logic primary_ref_input,
  output logic bus_clock_input
);
  int cnt_p = 0;
  int cnt_b = 0;
  logic pri_q = 1'b0;
  logic bus_q = 1'b0;
  // Rates kept slow against clk so each sampled level is seen
  // Locked to clk so that measured periods come out exact
  always_ff @(posedge clk) begin
    cnt_p <= (cnt_p >= HALF_PRI - 1) ? 0 : cnt_p + 1;
    cnt_b <= (cnt_b >= HALF_BUS - 1) ? 0 : cnt_b + 1;
    if (cnt_p >= HALF_PRI - 1) pri_q <= ~pri_q;
    if (cnt_b >= HALF_BUS - 1) bus_q <= ~bus_q;
  end
  // An agent board grounds the primary pin
  assign primary_ref_input = host_mode & pri_q;
  assign bus_clock_input = bus_q;
endmodule : scg_board_clk

/* File: bench/test_system_clock_generation_unit.sv */
// Self-checking bench of the system clock generation unit
`timescale 1ns/100ps
module test_system_clock_generation_unit;
  import scg_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic host_mode_strap = 1'b1;
  logic input_halving_strap = 1'b0;
  logic rcw_hard_sel = 1'b0;
  logic [DATA_W-1:0] reset_config_word_low = '0;
  logic primary_ref_input, bus_clock_input;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [DATA_W-1:0] s_axi_rdata;
  logic bus_sync_output, memory_bus_clock_out, memory_bus_clock_out_b, local_sync_output;
  logic [NUM_BUS_OUT-1:0] bus_clock_output_n;
  logic [NUM_LCLK-1:0] local_bus_clock_outputs;
  logic [NUM_UNITS-1:0] unit_clk_en;
  logic [17:0] pr;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // Reset option table: host, halving, fixed word, pin word
  logic [4:0] cs_h = 5'b10011;
  logic [4:0] cs_v = 5'b01010;
  logic [4:0] cs_d = 5'b01000;
  logic [31:0] cs_w [5] = '{32'h0000_1802, 32'h0000_0000, 32'h0000_0001, 32'hFFFF_E7FF,
                            32'hFFFF_F7F3};

  always #5 clk = ~clk;

  scg_board_clk scg_board_clk_inst (.clk, .host_mode(host_mode_strap), .primary_ref_input,
    .bus_clock_input);
  scg_clock_unit scg_clock_unit_inst (.clk, .rst_b, .host_mode_strap, .primary_ref_input,
    .bus_clock_input, .input_halving_strap, .rcw_hard_sel, .reset_config_word_low,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .bus_sync_output, .bus_clock_output_n,
    .memory_bus_clock_out, .memory_bus_clock_out_b, .local_sync_output,
    .local_bus_clock_outputs, .unit_clk_en);

  // Index 0-4 bus outputs, 5 sync, 6 memory, 7 local sync, 8 local clock, 9+ units
  assign pr = {unit_clk_en, local_bus_clock_outputs[0], local_sync_output,
               memory_bus_clock_out, bus_sync_output, bus_clock_output_n};

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task results;
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      results();
    end
  end

  task axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
    bit dn;
    dn = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !dn; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        check("write response", {30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        dn = 1'b1;
      end
    end
    check("write answered", {31'h0, dn}, 32'h1);
  endtask : axi_wr

  task rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
      input logic [1:0] er);
    bit dn;
    dn = 1'b0;
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !dn; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        check(what, s_axi_rdata, e);
        check("read response", {30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        dn = 1'b1;
      end
    end
    check("read answered", {31'h0, dn}, 32'h1);
  endtask : rd_chk

  // Cycles between two rising edges of a probe; 0 if it never rises twice
  task per(input int s, output logic [31:0] p);
    int r, t0;
    logic pv;
    pv = pr[s];
    r = 0;
    t0 = 0;
    p = '0;
    for (int n = 0; n < 300 && r < 2; n++) begin
      @(posedge clk);
      if (pr[s] === 1'b1 && pv === 1'b0) begin
        if (r == 1) p = n - t0;
        t0 = n;
        r++;
      end
      pv = pr[s];
    end
  endtask : per

  task do_reset(input int i);
    @(posedge clk);
    rst_b <= 1'b0;
    host_mode_strap <= cs_h[i];
    input_halving_strap <= cs_v[i];
    rcw_hard_sel <= cs_d[i];
    reset_config_word_low <= cs_w[i];
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  initial begin
    logic [31:0] p, w, st, f;
    int rf, lb;
    for (int i = 0; i < 5; i++) begin
      do_reset(i);
      w = cs_d[i] ? RCW_HARD_DEF : (cs_w[i] & 32'h0000_1FFF);
      f = (w[3:0] == 4'h0) ? 32'd16 : (w[3:0] == 4'h1) ? 32'd0 : {28'h0, w[3:0]};
      st = f | ((f * (1 + cs_v[i])) << 8) | (32'(cs_h[i]) << 16) |
           (32'(w[3:0] == 4'h1) << 17) | (32'(cs_v[i]) << 18);
      rd_chk("unit ratios", SYSTEM_CLOCK_CONTROL_REG_OFF, 32'h0000_7FFF, RESP_OKAY);
      rd_chk("output halving", OUTPUT_CLOCK_CONTROL_REG_OFF, 32'h0, RESP_OKAY);
      rd_chk("local divider", LOCAL_BUS_CLOCK_REG_OFF, 32'h0, RESP_OKAY);
      rd_chk("config word", RESET_CONFIG_WORD_LOW_OFF, w, RESP_OKAY);
      rd_chk("status", STAT_OFF, st, RESP_OKAY);
      rf = cs_h[i] ? 8 : 12;
      lb = w[12] ? 2 : 4;
      per(0, p); check("bus output period", p, rf);
      per(5, p); check("sync output period", p, rf * (1 + cs_v[i]));
      per(6, p); check("memory clock period", p, w[11] ? 2 : 4);
      check("memory pair", {31'h0, memory_bus_clock_out_b}, {31'h0, ~memory_bus_clock_out});
      per(9, p); check("ethernet default", p, 6);
      per(15, p); check("bus ctrl default", p, 2);
      axi_wr(OUTPUT_CLOCK_CONTROL_REG_OFF, 32'hFFFF_FFEA, RESP_OKAY);
      rd_chk("output halving", OUTPUT_CLOCK_CONTROL_REG_OFF, 32'h0000_000A, RESP_OKAY);
      for (int k = 0; k < 5; k++) begin
        per(k, p); check("bus output halved", p, rf * (1 + ((32'hA >> k) & 1)));
      end
      for (int k = 0; k < 4; k++) begin
        axi_wr(LOCAL_BUS_CLOCK_REG_OFF, k, RESP_OKAY);
        repeat (20) @(posedge clk);
        per(8, p); check("local clock", p, lb << ((k == 3) ? 2 : k));
        per(7, p); check("local sync", p, lb << ((k == 3) ? 2 : k));
      end
      // Security and USB units never at full rate, to respect their speed limit
      axi_wr(SYSTEM_CLOCK_CONTROL_REG_OFF, 32'hFFFF_5AE4, RESP_OKAY);
      rd_chk("unit ratios", SYSTEM_CLOCK_CONTROL_REG_OFF, 32'h0000_5AE4, RESP_OKAY);
      repeat (10) @(posedge clk);
      for (int k = 0; k < 9; k++) begin
        per(9 + k, p);
        check("unit spacing", p, (k < 6) ? 2 * ((32'h5AE4 >> (2 * k)) & 3) :
              2 * ((32'h5AE4 >> (6 + k)) & 1));
      end
      axi_wr(RESET_CONFIG_WORD_LOW_OFF, 32'h0, RESP_OKAY);
      rd_chk("config word kept", RESET_CONFIG_WORD_LOW_OFF, w, RESP_OKAY);
      axi_wr(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
      rd_chk("unmapped", 8'h14, 32'h0, RESP_SLVERR);
      rd_chk("misaligned", 8'h02, 32'h0, RESP_SLVERR);
    end
    results();
  end
endmodule : test_system_clock_generation_unit
